/* exec_pkg.sv */
// shared constants, types and helpers for the execution slice
package exec_pkg;

    // machine cycle length in core clocks, minus one
    localparam logic [3:0] MC_CLKS_M1 = 4'hb;
    localparam logic [1:0] MC_ONE = 2'h1;
    localparam logic [1:0] MC_TWO = 2'h2;

    // register byte offsets on the bus
    localparam logic [11:0] OFS_INSTR = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_PC = 12'h008;
    localparam logic [11:0] OFS_ACC = 12'h00c;
    localparam logic [11:0] OFS_PSW = 12'h010;
    localparam logic [11:0] OFS_PORT = 12'h014;
    localparam logic [2:0] RAM_WIN = 3'h1;

    // reset values
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [23:0] INSTR_RST = 24'h000000;

    // status word bit positions
    localparam int PSW_CY = 7;
    localparam int PSW_AC = 6;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_P = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_TAKEN = 1;
    localparam int STAT_ILLEGAL = 2;

    // opcodes
    localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_R = 8'hb8;
    localparam logic [7:0] OP_CLR_A = 8'he4;
    localparam logic [7:0] OP_CLR_C = 8'hc3;
    localparam logic [7:0] OP_CLR_BIT = 8'hc2;
    localparam logic [7:0] OP_CPL_A = 8'hf4;
    localparam logic [7:0] OP_CPL_C = 8'hb3;
    localparam logic [7:0] OP_CPL_BIT = 8'hb2;
    localparam logic [7:0] OP_DA_A = 8'hd4;
    localparam logic [7:0] OP_DEC_IND = 8'h16;

    // instruction lengths in bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;

    // bit space layout
    localparam logic [6:0] BIT_RAM_BASE = 7'h20;
    localparam logic [7:0] SFR_ACC = 8'he0;
    localparam logic [7:0] SFR_PSW = 8'hd0;
    localparam logic [7:0] SFR_PORT = 8'h90;

    // decimal adjust constants
    localparam logic [3:0] DA_LIMIT = 4'h9;
    localparam logic [8:0] DA_LO_STEP = 9'h006;
    localparam logic [8:0] DA_HI_STEP = 9'h060;

    typedef struct packed {
        logic [7:0] rel;
        logic [7:0] imm;
        logic [7:0] op;
    } instr_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [11:0] addr;
    } bus_req_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ISSUE = 5'b00010,
        ST_LOOK = 5'b00100,
        ST_DEREF = 5'b01000,
        ST_HOLD = 5'b10000
    } exec_state_t;

    // working register address in the active bank
    function automatic logic [6:0] bank_addr(input logic [7:0] program_status_word, input logic [2:0] r);
        return {2'b00, program_status_word[PSW_RS1], program_status_word[PSW_RS0], r};
    endfunction

    // clear or invert one bit of a byte
    function automatic logic [7:0] bit_mod(input logic [7:0] b, input logic [2:0] idx,
                                           input logic clr);
        logic [7:0] m;
        m = 8'h01 << idx;
        return clr ? (b & ~m) : (b ^ m);
    endfunction

    // decimal adjust: {carry out, result}
    function automatic logic [8:0] decimal_adjust(input logic [7:0] a, input logic cy,
                                                  input logic ac);
        logic [8:0] t;
        logic c1;
        t = {1'b0, a};
        if (ac || (a[3:0] > DA_LIMIT)) begin
            t = t + DA_LO_STEP;
        end
        c1 = t[8];
        if (cy || c1 || (t[7:4] > DA_LIMIT)) begin
            t = {1'b0, t[7:0]} + DA_HI_STEP;
        end
        return {t[8] | c1, t[7:0]};
    endfunction

endpackage

/* exec_slice.sv */
// compare, clear, complement, decimal adjust and decrement execution slice
//
// Behaviour
// - compare-and-branch takes two machine cycles and adds the signed offset when unequal.
// - compare-and-branch falls through to the next instruction when equal.
// - compare-and-branch sets carry when the immediate exceeds the register, else clears it.
// - clear accumulator is one byte, one cycle, loads zero and refreshes parity.
// - clear carry is one byte, one cycle, and touches no other flag.
// - clear bit is two bytes, one cycle, and zeroes the addressed bit.
// - complement accumulator is one byte, one cycle, and inverts every bit.
// - complement carry is one byte, one cycle, and toggles carry.
// - complement bit is two bytes, one cycle, and inverts the addressed bit.
// - decimal adjust adds 6 to the low digit when above 9 or auxiliary carry is set.
// - decimal adjust adds 6 to the high digit when above 9 or carry set, one byte, one cycle.
// - indirect decrement is one byte, one cycle, pointer picked by opcode bit 0, no flags.
`timescale 1ns/100ps
module exec_slice (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [7:0] o_port_latch,
    output logic o_busy
);

    // ---- bus side state
    exec_pkg::bus_req_t dp_reg;
    exec_pkg::bus_req_t dp_next;
    logic ram_wait_reg;

    // ---- architectural state
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic [7:0] psw_reg;
    logic [7:0] psw_next;
    logic [7:0] port_reg;
    logic [7:0] port_next;
    exec_pkg::instr_t instr_reg;
    exec_pkg::instr_t instr_next;
    exec_pkg::exec_state_t state_reg;
    exec_pkg::exec_state_t state_next;
    logic [6:0] ptr_reg;
    logic taken_reg;
    logic taken_next;
    logic illegal_reg;
    logic illegal_next;

    // ---- memory ports
    logic [6:0] a_addr;
    logic a_we;
    logic [7:0] a_wdata;
    logic [7:0] a_rdata;
    logic [7:0] b_rdata;
    logic elapsed;

    // ---- address phase capture
    wire ap_valid = i_hsel && i_htrans[1] && i_hready;
    assign dp_next = '{sel: ap_valid, wr: i_hwrite, addr: i_haddr[11:0]};

    // ---- data phase decode
    wire wr_en = dp_reg.sel && dp_reg.wr;
    wire rd_en = dp_reg.sel && !dp_reg.wr;
    wire hit_instr = (dp_reg.addr == exec_pkg::OFS_INSTR);
    wire hit_stat = (dp_reg.addr == exec_pkg::OFS_STAT);
    wire hit_pc = (dp_reg.addr == exec_pkg::OFS_PC);
    wire hit_acc = (dp_reg.addr == exec_pkg::OFS_ACC);
    wire hit_psw = (dp_reg.addr == exec_pkg::OFS_PSW);
    wire hit_port = (dp_reg.addr == exec_pkg::OFS_PORT);
    wire hit_ram = (dp_reg.addr[11:9] == exec_pkg::RAM_WIN) && (dp_reg.addr[1:0] == 2'h0);
    wire ram_rd = rd_en && hit_ram;
    wire idle = (state_reg == exec_pkg::ST_IDLE);
    wire sw_wr = wr_en && idle;
    wire start = sw_wr && hit_instr;

    // ---- parity is always that of the current accumulator
    wire parity = ^acc_reg;
    wire [7:0] psw_view = {psw_reg[7:1], parity};

    // ---- bus answers: ram reads take one wait state, all else none
    assign o_hreadyout = !(ram_rd && !ram_wait_reg);
    assign o_hresp = 1'b0;
    assign o_busy = !idle;
    assign o_port_latch = port_reg;

    // ---- read data select
    always_comb begin
        o_hrdata = 32'h0000_0000;
        if (rd_en) begin
            if (hit_instr) begin
                o_hrdata = {8'h00, instr_reg};
            end else if (hit_stat) begin
                o_hrdata[exec_pkg::STAT_BUSY] = !idle;
                o_hrdata[exec_pkg::STAT_TAKEN] = taken_reg;
                o_hrdata[exec_pkg::STAT_ILLEGAL] = illegal_reg;
            end else if (hit_pc) begin
                o_hrdata = {16'h0000, pc_reg};
            end else if (hit_acc) begin
                o_hrdata = {24'h000000, acc_reg};
            end else if (hit_psw) begin
                o_hrdata = {24'h000000, psw_view};
            end else if (hit_port) begin
                o_hrdata = {24'h000000, port_reg};
            end else if (hit_ram) begin
                o_hrdata = {24'h000000, b_rdata};
            end
        end
    end

    // ---- opcode decode of the held instruction
    wire [7:0] op = instr_reg.op;
    wire is_compare_jump_not_equal = (op[7:3] == exec_pkg::OP_COMPARE_JUMP_NOT_EQUAL_R[7:3]);
    wire is_clra = (op == exec_pkg::OP_CLR_A);
    wire is_clrc = (op == exec_pkg::OP_CLR_C);
    wire is_clrb = (op == exec_pkg::OP_CLR_BIT);
    wire is_cpla = (op == exec_pkg::OP_CPL_A);
    wire is_cplc = (op == exec_pkg::OP_CPL_C);
    wire is_cplb = (op == exec_pkg::OP_CPL_BIT);
    wire is_da = (op == exec_pkg::OP_DA_A);
    wire is_dec = (op[7:1] == exec_pkg::OP_DEC_IND[7:1]);
    wire is_bitop = is_clrb || is_cplb;
    wire known = is_compare_jump_not_equal || is_clra || is_clrc || is_bitop || is_cpla || is_cplc
                 || is_da || is_dec;

    // ---- machine cycles of the instruction being written
    wire new_compare_jump_not_equal = (i_hwdata[7:3] == exec_pkg::OP_COMPARE_JUMP_NOT_EQUAL_R[7:3]);
    wire [1:0] new_cycles = new_compare_jump_not_equal ? exec_pkg::MC_TWO : exec_pkg::MC_ONE;

    // ---- bit address decode
    wire [7:0] bit_addr = instr_reg.imm;
    wire [2:0] bit_idx = bit_addr[2:0];
    wire bit_in_ram = !bit_addr[7];
    wire [6:0] bit_byte = exec_pkg::BIT_RAM_BASE + {3'h0, bit_addr[6:3]};
    wire [7:0] sfr_byte = {bit_addr[7:3], 3'h0};
    wire bit_acc = is_bitop && !bit_in_ram && (sfr_byte == exec_pkg::SFR_ACC);
    wire bit_psw = is_bitop && !bit_in_ram && (sfr_byte == exec_pkg::SFR_PSW);
    wire bit_port = is_bitop && !bit_in_ram && (sfr_byte == exec_pkg::SFR_PORT);

    // ---- first memory byte: working register, pointer or bit byte
    wire [6:0] reg_sel = exec_pkg::bank_addr(psw_reg, op[2:0]);
    wire [6:0] ptr_sel = exec_pkg::bank_addr(psw_reg, {2'h0, op[0]});
    wire [6:0] first_addr = is_compare_jump_not_equal ? reg_sel : (is_dec ? ptr_sel : bit_byte);

    // ---- compare against the immediate byte
    wire cmp_ne = (a_rdata != instr_reg.imm);
    wire cmp_lt = (a_rdata < instr_reg.imm);

    // ---- branch target from the address after the instruction
    wire [15:0] len = is_compare_jump_not_equal ? exec_pkg::LEN_THREE
                    : (is_bitop ? exec_pkg::LEN_TWO : exec_pkg::LEN_ONE);
    wire [15:0] rel16 = {{8{instr_reg.rel[7]}}, instr_reg.rel};
    wire [15:0] seq_pc = pc_reg + len;
    wire [15:0] jmp_pc = seq_pc + rel16;

    // ---- decimal adjust result
    wire [8:0] da_res = exec_pkg::decimal_adjust(acc_reg, psw_reg[exec_pkg::PSW_CY],
                                                 psw_reg[exec_pkg::PSW_AC]);

    // ---- engine memory port
    wire in_look = (state_reg == exec_pkg::ST_LOOK);
    wire in_deref = (state_reg == exec_pkg::ST_DEREF);
    assign a_addr = (in_look && is_dec) ? a_rdata[6:0] : (in_deref ? ptr_reg : first_addr);
    assign a_we = (in_look && is_bitop && bit_in_ram) || in_deref;
    assign a_wdata = in_deref ? (a_rdata - 8'h01)
                   : exec_pkg::bit_mod(a_rdata, bit_idx, is_clrb);

    // ---- engine sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            exec_pkg::ST_IDLE: begin
                if (start) begin
                    state_next = exec_pkg::ST_ISSUE;
                end
            end
            exec_pkg::ST_ISSUE: begin
                state_next = exec_pkg::ST_LOOK;
            end
            exec_pkg::ST_LOOK: begin
                state_next = is_dec ? exec_pkg::ST_DEREF : exec_pkg::ST_HOLD;
            end
            exec_pkg::ST_DEREF: begin
                state_next = exec_pkg::ST_HOLD;
            end
            exec_pkg::ST_HOLD: begin
                if (elapsed) begin
                    state_next = exec_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = exec_pkg::ST_IDLE;
            end
        endcase
    end

    // ---- architectural updates: software while idle, engine in look
    always_comb begin
        pc_next = pc_reg;
        acc_next = acc_reg;
        psw_next = psw_reg;
        port_next = port_reg;
        instr_next = instr_reg;
        taken_next = taken_reg;
        illegal_next = illegal_reg;
        if (sw_wr) begin
            if (hit_instr) begin
                instr_next = i_hwdata[23:0];
            end
            if (hit_pc) begin
                pc_next = i_hwdata[15:0];
            end
            if (hit_acc) begin
                acc_next = i_hwdata[7:0];
            end
            if (hit_psw) begin
                psw_next = i_hwdata[7:0];
            end
            if (hit_port) begin
                port_next = i_hwdata[7:0];
            end
        end else if (in_look) begin
            pc_next = (is_compare_jump_not_equal && cmp_ne) ? jmp_pc : seq_pc;
            taken_next = is_compare_jump_not_equal && cmp_ne;
            illegal_next = !known;
            if (is_compare_jump_not_equal) begin
                psw_next[exec_pkg::PSW_CY] = cmp_lt;
            end
            if (is_clra) begin
                acc_next = 8'h00;
            end
            if (is_cpla) begin
                acc_next = ~acc_reg;
            end
            if (is_clrc) begin
                psw_next[exec_pkg::PSW_CY] = 1'b0;
            end
            if (is_cplc) begin
                psw_next[exec_pkg::PSW_CY] = !psw_reg[exec_pkg::PSW_CY];
            end
            if (is_da) begin
                acc_next = da_res[7:0];
                psw_next[exec_pkg::PSW_CY] = psw_reg[exec_pkg::PSW_CY] | da_res[8];
            end
            if (bit_acc) begin
                acc_next = exec_pkg::bit_mod(acc_reg, bit_idx, is_clrb);
            end
            if (bit_psw) begin
                psw_next = exec_pkg::bit_mod(psw_view, bit_idx, is_clrb);
            end
            if (bit_port) begin
                port_next = exec_pkg::bit_mod(port_reg, bit_idx, is_clrb);
            end
        end
    end

    // ---- bus phase registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_reg <= '0;
            ram_wait_reg <= 1'b0;
        end else begin
            if (i_hready) begin
                dp_reg <= dp_next;
            end
            ram_wait_reg <= ram_rd && !ram_wait_reg;
        end
    end

    // ---- architectural registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_reg <= exec_pkg::PC_RST;
            acc_reg <= exec_pkg::ACC_RST;
            psw_reg <= exec_pkg::PSW_RST;
            port_reg <= exec_pkg::PORT_RST;
            instr_reg <= exec_pkg::INSTR_RST;
            taken_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            psw_reg <= psw_next;
            port_reg <= port_next;
            instr_reg <= instr_next;
            taken_reg <= taken_next;
            illegal_reg <= illegal_next;
        end
    end

    // ---- engine state and pointer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= exec_pkg::ST_IDLE;
            ptr_reg <= 7'h00;
        end else begin
            state_reg <= state_next;
            if (in_look) begin
                ptr_reg <= a_rdata[6:0];
            end
        end
    end

    // ---- instruction length in machine cycles
    machine_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .i_cycles(new_cycles),
        .o_elapsed(elapsed)
    );

    // ---- internal data memory: engine on port a, bus on port b
    iram_mem u_iram (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_a_addr(a_addr),
        .i_a_we(a_we),
        .i_a_wdata(a_wdata),
        .o_a_rdata(a_rdata),
        .i_b_addr(dp_reg.addr[8:2]),
        .i_b_we(wr_en && hit_ram),
        .i_b_wdata(i_hwdata[7:0]),
        .o_b_rdata(b_rdata)
    );

endmodule // exec_slice

/* exec_slice_monitor.sv */
// timing and bus checks on the execution slice ports
`timescale 1ns/100ps
module exec_slice_monitor (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [7:0] o_port_latch,
    input wire logic o_busy
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic dp_reg, dp_wr_reg;
    logic [11:0] dp_addr_reg;
    logic [7:0] op_reg, busy_cnt_reg;
    // data phase decode
    wire dp_end = dp_reg & i_hready;
    wire instr_go = dp_end & dp_wr_reg & (dp_addr_reg == exec_pkg::OFS_INSTR) & !o_busy;
    wire port_wr = dp_end & dp_wr_reg & (dp_addr_reg == exec_pkg::OFS_PORT);
    wire is_cmp = (op_reg[7:3] == exec_pkg::OP_COMPARE_JUMP_NOT_EQUAL_R[7:3]);
    // data phase tracking, opcode capture, busy length
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_reg <= 1'b0;
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 12'h000;
            op_reg <= 8'h00;
            busy_cnt_reg <= 8'h00;
        end else begin
            if (i_hready) begin
                dp_reg <= i_hsel & i_htrans[1];
                dp_wr_reg <= i_hwrite;
                dp_addr_reg <= i_haddr[11:0];
            end
            if (instr_go) op_reg <= i_hwdata[7:0];
            busy_cnt_reg <= o_busy ? busy_cnt_reg + 8'h01 : 8'h00;
        end
    end
    property p_busy_start; instr_go |=> o_busy; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy did not follow start");
    property p_busy_cause; $rose(o_busy) |-> $past(instr_go); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    property p_cmp_len; $fell(o_busy) && is_cmp |-> busy_cnt_reg inside {[22:28]}; endproperty
    a_cmp_len: assert property (p_cmp_len) else $error("compare length wrong");
    property p_one_len; $fell(o_busy) && !is_cmp |-> busy_cnt_reg inside {[10:16]}; endproperty
    a_one_len: assert property (p_one_len) else $error("single cycle op length wrong");
    property p_port_src; !$stable(o_port_latch) |-> $past(o_busy) || $past(port_wr); endproperty
    a_port_src: assert property (p_port_src) else $error("port latch changed idle");
    property p_port_rst; $rose(i_rst_n) |-> o_port_latch == exec_pkg::PORT_RST; endproperty
    a_port_rst: assert property (p_port_rst) else $error("port latch reset value wrong");
    property p_wait_one; !o_hreadyout |=> o_hreadyout; endproperty
    a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
    property p_wr_ready; dp_reg && dp_wr_reg |-> o_hreadyout; endproperty
    a_wr_ready: assert property (p_wr_ready) else $error("write data phase stalled");
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
endmodule // exec_slice_monitor
bind exec_slice exec_slice_monitor exec_slice_monitor_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_port_latch(o_port_latch), .o_busy(o_busy));

/* exec_slice_tb.sv */
// self-checking bench driving the execution slice over its register bus
`timescale 1ns/100ps
module exec_slice_tb;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, busy;
    logic [7:0] port_latch;
    logic [31:0] rdv;
    logic [15:0] pc_exp;
    int n_mismatch = 0;
    int cmp_count = 0;
    // acc in, psw in, acc out, carry out
    logic [31:0] da_tab [5] = '{32'h9b000180, 32'h56405c00, 32'h12807280, 32'h3a004000,
                                32'ha0000080};
    // register index, register value, immediate, offset
    logic [31:0] cj_tab [4] = '{32'h051020fe, 32'h02202010, 32'h07807f05, 32'h007f8080};

    // core clock, 5 ns period
    always #2.5 i_core_clk = ~i_core_clk;

    exec_slice exec_slice_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
        .o_hresp(hresp), .o_port_latch(port_latch), .o_busy(busy));

    // verdict and end of run
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // wait for ready at a rising edge, ready and read data sampled at the falling edge before it
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            r = hreadyout;
            d = hrdata;
            @(posedge i_core_clk);
            n++;
        end while (r !== 1'b1 && n < 40);
        if (r !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // one single word transfer
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, rdv);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h00000000, rdv);
        chk(rdv, e);
    endtask

    // issue one instruction and wait for busy to drop
    task automatic ex(input logic [23:0] i);
        int n;
        n = 0;
        wr(exec_pkg::OFS_INSTR, {8'h00, i});
        do begin
            @(negedge i_core_clk);
            n++;
        end while (busy !== 1'b0 && n < 80);
        @(posedge i_core_clk);
        if (n >= 80) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rdc(exec_pkg::OFS_PORT, 32'h000000ff);
        rdc(exec_pkg::OFS_PC, 32'h00000000);
        rdc(12'h100, 32'h00000000);
        // accumulator complement then clear
        wr(exec_pkg::OFS_ACC, 32'h000000d5);
        ex({16'h0000, exec_pkg::OP_CPL_A});
        rdc(exec_pkg::OFS_ACC, 32'h0000002a);
        rdc(exec_pkg::OFS_PSW, 32'h00000001);
        ex({16'h0000, exec_pkg::OP_CLR_A});
        rdc(exec_pkg::OFS_ACC, 32'h00000000);
        rdc(exec_pkg::OFS_PSW, 32'h00000000);
        rdc(exec_pkg::OFS_PC, 32'h00000002);
        // carry clear and toggle, other flags kept
        wr(exec_pkg::OFS_PSW, 32'h000000c0);
        ex({16'h0000, exec_pkg::OP_CLR_C});
        rdc(exec_pkg::OFS_PSW, 32'h00000040);
        ex({16'h0000, exec_pkg::OP_CPL_C});
        rdc(exec_pkg::OFS_PSW, 32'h000000c0);
        ex({16'h0000, exec_pkg::OP_CPL_C});
        rdc(exec_pkg::OFS_PSW, 32'h00000040);
        // port latch and memory bit operations
        ex({16'h0095, exec_pkg::OP_CLR_BIT});
        rdc(exec_pkg::OFS_PORT, 32'h000000df);
        ex({16'h0095, exec_pkg::OP_CPL_BIT});
        ex({16'h0090, exec_pkg::OP_CPL_BIT});
        rdc(exec_pkg::OFS_PORT, 32'h000000fe);
        rdc(exec_pkg::OFS_PC, 32'h0000000b);
        wr(12'h284, 32'h0000000f);
        ex({16'h000b, exec_pkg::OP_CLR_BIT});
        rdc(12'h284, 32'h00000007);
        ex({16'h000f, exec_pkg::OP_CPL_BIT});
        rdc(12'h284, 32'h00000087);
        // indirect decrement through both pointers
        wr(12'h200, 32'h00000030);
        wr(12'h204, 32'h00000031);
        wr(12'h2c0, 32'h00000000);
        wr(12'h2c4, 32'h00000010);
        wr(exec_pkg::OFS_PSW, 32'h000000c0);
        ex({16'h0000, exec_pkg::OP_DEC_IND});
        ex({16'h0000, exec_pkg::OP_DEC_IND | 8'h01});
        rdc(12'h2c0, 32'h000000ff);
        rdc(12'h2c4, 32'h0000000f);
        rdc(exec_pkg::OFS_PSW, 32'h000000c0);
        // decimal adjust table
        for (int i = 0; i < 5; i++) begin
            wr(exec_pkg::OFS_ACC, {24'h000000, da_tab[i][31:24]});
            wr(exec_pkg::OFS_PSW, {24'h000000, da_tab[i][23:16]});
            ex({16'h0000, exec_pkg::OP_DA_A});
            rdc(exec_pkg::OFS_ACC, {24'h000000, da_tab[i][15:8]});
            xfer(exec_pkg::OFS_PSW, 1'b0, 32'h00000000, rdv);
            chk(rdv & 32'h00000080, {24'h000000, da_tab[i][7:0]});
        end
        // compare and branch in bank one
        for (int i = 0; i < 4; i++) begin
            wr(exec_pkg::OFS_PSW, 32'h00000008);
            wr(exec_pkg::OFS_PC, 32'h00000100);
            wr(12'h220 + {4'h0, cj_tab[i][26:24], 2'b00}, {24'h000000, cj_tab[i][23:16]});
            ex({cj_tab[i][7:0], cj_tab[i][15:8], exec_pkg::OP_COMPARE_JUMP_NOT_EQUAL_R | cj_tab[i][31:24]});
            pc_exp = 16'h0103;
            if (cj_tab[i][23:16] != cj_tab[i][15:8]) pc_exp += {{8{cj_tab[i][7]}}, cj_tab[i][7:0]};
            rdc(exec_pkg::OFS_PC, {16'h0000, pc_exp});
            rdc(exec_pkg::OFS_STAT, {30'h0, cj_tab[i][23:16] != cj_tab[i][15:8], 1'b0});
            xfer(exec_pkg::OFS_PSW, 1'b0, 32'h00000000, rdv);
            chk(rdv[7], cj_tab[i][15:8] > cj_tab[i][23:16]);
        end
        // opcode outside this slice runs as a one byte no-op
        ex(24'h000000);
        rdc(exec_pkg::OFS_STAT, 32'h00000004);
        rdc(exec_pkg::OFS_PC, 32'h00000084);
        conclude();
    end
endmodule // exec_slice_tb

/* iram_mem.sv */
// internal data memory, 128 bytes, two ports with registered reads
`timescale 1ns/100ps
module iram_mem (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [6:0] i_a_addr,
    input wire logic i_a_we,
    input wire logic [7:0] i_a_wdata,
    output logic [7:0] o_a_rdata,
    input wire logic [6:0] i_b_addr,
    input wire logic i_b_we,
    input wire logic [7:0] i_b_wdata,
    output logic [7:0] o_b_rdata
);
    logic [7:0] mem [0:127];

    // port a written last so the engine wins a same-address clash
    always_ff @(posedge i_core_clk) begin
        if (i_b_we) begin
            mem[i_b_addr] <= i_b_wdata;
        end
        if (i_a_we) begin
            mem[i_a_addr] <= i_a_wdata;
        end
    end

    // registered read data
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_a_rdata <= 8'h00;
            o_b_rdata <= 8'h00;
        end else begin
            o_a_rdata <= mem[i_a_addr];
            o_b_rdata <= mem[i_b_addr];
        end
    end
endmodule // iram_mem

/* machine_timer.sv */
// machine cycle divider and instruction length timer
`timescale 1ns/100ps
module machine_timer (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_cycles,
    output logic o_elapsed
);
    logic [3:0] div_reg;
    logic [1:0] mc_reg;
    wire tick = (div_reg == exec_pkg::MC_CLKS_M1);
    wire [1:0] mc_inc = mc_reg + 2'h1;

    // count machine cycles from start until the length is reached
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg <= 4'h0;
            mc_reg <= 2'h0;
            o_elapsed <= 1'b1;
        end else if (i_start) begin
            div_reg <= 4'h0;
            mc_reg <= 2'h0;
            o_elapsed <= 1'b0;
        end else if (!o_elapsed) begin
            div_reg <= tick ? 4'h0 : div_reg + 4'h1;
            mc_reg <= tick ? mc_inc : mc_reg;
            o_elapsed <= tick && (mc_inc == i_cycles);
        end
    end
endmodule // machine_timer
